// ==== logic/irq_mask_regs.svh ====
// register offsets, field positions, write masks and reset values of the interrupt masks
`ifndef IRQ_MASK_REGS_SVH
`define IRQ_MASK_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define SERIAL_ERROR_FLAG_OFS 8'h53
`define SUPPLY_THERMAL_IRQ_MASK_OFS 8'h57
`define SERIAL_ERROR_IRQ_MASK_OFS 8'h58
`define BUS_FAULT_IRQ_MASK_OFS 8'h59
`define RESERVED_IRQ_MASK_FIRST_OFS 8'h5A
`define RESERVED_IRQ_MASK_LAST_OFS 8'h5F

// ----------------------------------------
// reset values
// ----------------------------------------
`define SUPPLY_THERMAL_IRQ_MASK_RST 8'h3F
`define SERIAL_ERROR_IRQ_MASK_RST 8'h80
`define BUS_FAULT_IRQ_MASK_RST 8'h7F
`define RESERVED_IRQ_MASK_RST 8'h00

// ----------------------------------------
// writable bits
// ----------------------------------------
`define SUPPLY_THERMAL_IRQ_MASK_WMASK 8'h37
`define SERIAL_ERROR_IRQ_MASK_WMASK 8'h80
`define BUS_FAULT_IRQ_MASK_WMASK 8'h3F

// ----------------------------------------
// field positions
// ----------------------------------------
`define VOUT_OVERVOLTAGE_IRQ_EN_BIT 5
`define BATTERY_UNDERVOLTAGE_IRQ_EN_BIT 4
`define VOUT_UNDERVOLTAGE_IRQ_EN_BIT 2
`define THERMAL_SHUTDOWN_IRQ_EN_BIT 1
`define THERMAL_WARNING_IRQ_EN_BIT 0
`define SERIAL_ERROR_IRQ_EN_BIT 7
`define SERIAL_ERROR_FLAG_BIT 7
`define LINES_SHORTED_IRQ_EN_BIT 5
`define HIGH_LINE_TO_BATTERY_IRQ_EN_BIT 4
`define LOW_LINE_TO_GROUND_IRQ_EN_BIT 3
`define BUS_OPEN_IRQ_EN_BIT 2
`define BUS_TO_GROUND_IRQ_EN_BIT 1
`define BUS_TO_BATTERY_IRQ_EN_BIT 0

`endif

// ==== logic/irq_mask_pkg.sv ====
// types shared by the interrupt mask bank
package irq_mask_pkg;

	// ----------------------------------------
	// register access request
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// ----------------------------------------
	// read answer
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} reg_rsp_t;

	// ----------------------------------------
	// enables handed to the interrupt logic
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] supply_thermal;
		logic [7:0] serial_error;
		logic [7:0] bus_fault;
	} irq_masks_t;

endpackage

// ==== logic/serial_error_flag_reg.sv ====
// sticky serial error flag, set by hardware, cleared by writing one
`timescale 1ns/100ps
module serial_error_flag_reg
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic set_in,
	input wire logic clear_in,
	output logic flag_out
);

	logic flag_q;

	// ----------------------------------------
	// flag storage, set beats clear
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			flag_q <= 1'b0;
		end
		else if (set_in)
		begin
			flag_q <= 1'b1;
		end
		else if (clear_in)
		begin
			flag_q <= 1'b0;
		end
	end

	assign flag_out = flag_q;

endmodule

// ==== logic/interrupt_enable_masks.sv ====
// interrupt enable mask register bank with masked interrupt indication
`timescale 1ns/100ps
`include "irq_mask_regs.svh"

// Operation
// - supply mask at 0x57 resets 0x3F; bits 7, 6 read zero; bit 3 resets one and any write clears it.
// - supply bit 5 enables regulated output overvoltage interrupt, resets one.
// - supply bit 4 enables battery undervoltage interrupt, resets one.
// - supply bit 2 enables regulated output undervoltage interrupt, resets one.
// - supply bits 1 and 0 enable thermal shutdown and warning, reset one.
// - serial mask at 0x58 resets 0x80; bit 7 writable, rest zero.
// - bus mask at 0x59 resets 0x7F; bit 7 reads zero; bit 6 resets one and any write clears it.
// - bus bit 5 enables lines shorted together interrupt.
// - bus bits 4, 3 enable high line to battery, low line to ground.
// - bus bits 2, 1, 0 enable open, to ground, to battery.
// - offsets 0x5A to 0x5F are reserved, read zero, ignore writes.
// - serial error flag sets on serial error event; writing one clears it.
module interrupt_enable_masks
	import irq_mask_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire reg_req_t reg_req_in,
	input wire logic [7:0] supply_flags_in,
	input wire logic [7:0] bus_fault_flags_in,
	input wire logic serial_status_error_in,
	output reg_rsp_t reg_rsp_out,
	output irq_masks_t masks_out,
	output logic irq_out
);

	logic [7:0] supply_q;
	logic [7:0] serial_q;
	logic [7:0] bus_q;
	reg_rsp_t rsp_q;
	reg_rsp_t rsp_d;
	logic irq_q;
	logic irq_d;
	logic serial_error_flag;
	logic flag_clear;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] masked_write(input logic [7:0] wdata, input logic [7:0] wmask);
		masked_write = wdata & wmask;
	endfunction

	function automatic logic is_write(input reg_req_t req, input logic [7:0] ofs);
		is_write = req.valid && req.write && (req.addr == ofs);
	endfunction

	// ----------------------------------------
	// mask registers
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			supply_q <= `SUPPLY_THERMAL_IRQ_MASK_RST;
		end
		else if (is_write(reg_req_in, `SUPPLY_THERMAL_IRQ_MASK_OFS))
		begin
			supply_q <= masked_write(reg_req_in.wdata, `SUPPLY_THERMAL_IRQ_MASK_WMASK);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			serial_q <= `SERIAL_ERROR_IRQ_MASK_RST;
		end
		else if (is_write(reg_req_in, `SERIAL_ERROR_IRQ_MASK_OFS))
		begin
			serial_q <= masked_write(reg_req_in.wdata, `SERIAL_ERROR_IRQ_MASK_WMASK);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			bus_q <= `BUS_FAULT_IRQ_MASK_RST;
		end
		else if (is_write(reg_req_in, `BUS_FAULT_IRQ_MASK_OFS))
		begin
			bus_q <= masked_write(reg_req_in.wdata, `BUS_FAULT_IRQ_MASK_WMASK);
		end
	end

	// ----------------------------------------
	// serial error flag
	// ----------------------------------------
	assign flag_clear = is_write(reg_req_in, `SERIAL_ERROR_FLAG_OFS)
		&& reg_req_in.wdata[`SERIAL_ERROR_FLAG_BIT];

	serial_error_flag_reg u_serial_error_flag
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.set_in(serial_status_error_in),
		.clear_in(flag_clear),
		.flag_out(serial_error_flag)
	);

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb
	begin
		rsp_d.valid = reg_req_in.valid && !reg_req_in.write;
		rsp_d.data = 8'h00;
		if (reg_req_in.addr == `SUPPLY_THERMAL_IRQ_MASK_OFS)
		begin
			rsp_d.data = supply_q;
		end
		else if (reg_req_in.addr == `SERIAL_ERROR_IRQ_MASK_OFS)
		begin
			rsp_d.data = serial_q;
		end
		else if (reg_req_in.addr == `BUS_FAULT_IRQ_MASK_OFS)
		begin
			rsp_d.data = bus_q;
		end
		else if (reg_req_in.addr == `SERIAL_ERROR_FLAG_OFS)
		begin
			rsp_d.data = {serial_error_flag, 7'h00};
		end
		if (!rsp_d.valid)
		begin
			rsp_d.data = 8'h00;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			rsp_q <= '0;
		end
		else
		begin
			rsp_q <= rsp_d;
		end
	end

	// ----------------------------------------
	// interrupt indication
	// ----------------------------------------
	assign irq_d = (|(supply_flags_in & supply_q))
		|| (serial_error_flag && serial_q[`SERIAL_ERROR_IRQ_EN_BIT])
		|| (|(bus_fault_flags_in & bus_q));

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= irq_d;
		end
	end

	assign reg_rsp_out = rsp_q;
	assign masks_out = '{supply_thermal: supply_q, serial_error: serial_q, bus_fault: bus_q};
	assign irq_out = irq_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking

	a_supply_reset_value: assert property (rst_in |=> supply_q == 8'h3F)
		else $error("supply mask reset value wrong");
	a_supply_bit_five: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h57) |=> supply_q[5] == $past(reg_req_in.wdata[5]))
		else $error("supply bit 5 did not take write");
	a_supply_bit_four: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h57) |=> supply_q[4] == $past(reg_req_in.wdata[4]))
		else $error("supply bit 4 did not take write");
	a_supply_bit_two: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h57) |=> supply_q[2] == $past(reg_req_in.wdata[2]))
		else $error("supply bit 2 did not take write");
	a_thermal_enable_bits: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h57)
		|=> supply_q[1:0] == $past(reg_req_in.wdata[1:0]) && supply_q[7:6] == 2'h0
		&& !supply_q[3])
		else $error("thermal enables or reserved supply bits wrong");
	a_serial_mask_write: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h58) |=> serial_q == {$past(reg_req_in.wdata[7]), 7'h00})
		else $error("serial mask write wrong");
	a_bus_reserved_zero: assert property (rst_in ##1 !rst_in [*3] |-> bus_q[7:6] == 2'h0
		&& $past(bus_q, 3) == 8'h7F || $past(rst_in, 2))
		else $error("bus mask reserved bits or reset wrong");
	a_bus_short_bit: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h59) |=> bus_q[5] == $past(reg_req_in.wdata[5]))
		else $error("bus shorted enable did not take write");
	a_bus_line_bits: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h59) |=> bus_q[4:3] == $past(reg_req_in.wdata[4:3]))
		else $error("bus line enables did not take write");
	a_bus_low_bits: assert property (disable iff (rst_in)
		is_write(reg_req_in, 8'h59) ##1 !reg_req_in.valid [*2]
		|-> bus_q[2:0] == $past(reg_req_in.wdata[2:0], 2))
		else $error("bus low enables did not hold write");
	a_reserved_read_zero: assert property (disable iff (rst_in)
		reg_req_in.valid && !reg_req_in.write && reg_req_in.addr >= 8'h5A
		&& reg_req_in.addr <= 8'h5F |=> reg_rsp_out.valid && reg_rsp_out.data == 8'h00)
		else $error("reserved slot read not zero");
	a_flag_set_wins: assert property (disable iff (rst_in)
		serial_status_error_in |=> serial_error_flag ##0 reg_rsp_out.valid
		|| !$past(reg_req_in.valid) || $past(reg_req_in.write))
		else $error("serial error flag not set");
	a_flag_clear: assert property (disable iff (rst_in)
		flag_clear && !serial_status_error_in |=> !serial_error_flag)
		else $error("serial error flag not cleared");
	a_irq_follows_mask: assert property (disable iff (rst_in)
		(|(bus_fault_flags_in & bus_q)) |=> irq_out ##0 $past(irq_d))
		else $error("masked bus fault did not raise interrupt");
	a_irq_quiet: assert property (disable iff (rst_in)
		supply_q == 8'h00 && serial_q == 8'h00 && bus_q == 8'h00 |=> !irq_out)
		else $error("interrupt raised with all enables off");

	c_irq_raised: cover property (disable iff (rst_in) !irq_out ##1 irq_out);
	c_flag_cleared: cover property (disable iff (rst_in) serial_error_flag ##1 flag_clear);
	c_mask_read: cover property (disable iff (rst_in)
		reg_req_in.valid && !reg_req_in.write && reg_req_in.addr == 8'h59);
	c_set_and_clear: cover property (disable iff (rst_in) serial_status_error_in && flag_clear);

endmodule

// ==== tb/host_model.sv ====
// host model issuing single byte register accesses to the mask bank
`timescale 1ns/100ps
module host_model
	import irq_mask_pkg::*;
(
	input wire logic clk_in,
	input wire reg_rsp_t rsp_in,
	output reg_req_t req_out
);
	reg_rsp_t got;
	initial req_out = '0;
	// ----------------------------------------
	// one access held to its taking edge
	// ----------------------------------------
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1 req_out = {1'b1, w, a, d};
		@(posedge clk_in);
		#1 got = rsp_in;
		req_out = {1'b0, ~w, ~a, ~d};
	endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench of the interrupt enable mask bank
`timescale 1ns/100ps
module tb
	import irq_mask_pkg::*;
;
	logic clk_in, rst_in, err_in, irq_out, sflag;
	logic [7:0] sup_in, bus_in;
	logic [23:0] mv;
	logic [31:0] x;
	int error_cnt, num_checks;
	reg_req_t req;
	reg_rsp_t rsp;
	irq_masks_t masks_out;
	interrupt_enable_masks dut (.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req),
		.supply_flags_in(sup_in), .bus_fault_flags_in(bus_in),
		.serial_status_error_in(err_in), .reg_rsp_out(rsp), .masks_out(masks_out),
		.irq_out(irq_out));
	host_model u_host (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
	initial
	begin
		clk_in = 0;
		forever #50 clk_in = ~clk_in;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x[7:0];
	endfunction
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h53: return {sflag, 7'h00};
			8'h57: return mv[23:16];
			8'h58: return mv[15:8];
			8'h59: return mv[7:0];
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.acc(1'b1, a, d);
		case (a)
			8'h53: if (d[7]) sflag = 1'b0;
			8'h57: mv[23:16] = d & 8'h37;
			8'h58: mv[15:8] = d & 8'h80;
			8'h59: mv[7:0] = d & 8'h3F;
			default: ;
		endcase
		chk("masks", mv, masks_out);
	endtask
	task automatic rd(input logic [7:0] a);
		u_host.acc(1'b0, a, 8'h00);
		chk("read", {15'h0000, 1'b1, exp_rd(a)}, {15'h0000, u_host.got});
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_in);
		#1 chk("irq", |({sup_in, bus_in} & {mv[23:16], mv[7:0]}) | (sflag & mv[15]), irq_out);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		rst_in = 1;
		err_in = 0;
		sup_in = 0;
		bus_in = 0;
		x = 26;
		mv = 24'h3F807F;
		sflag = 0;
		repeat (12) @(posedge clk_in);
		#1 rst_in = 0;
		chk("masks", mv, masks_out);
		rd(8'h57);
		rd(8'h58);
		rd(8'h59);
		for (int a = 'h5A; a <= 'h60; a++)
		begin
			wr(a[7:0], 8'hFF);
			rd(a[7:0]);
		end
		for (int i = 0; i < 36; i++)
		begin
			logic [7:0] a;
			a = 8'h57 + 8'(i % 3);
			wr(a, i < 3 ? 8'hFF : (i < 6 ? 8'h00 : rnd()));
			rd(a);
		end
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h57, ~(8'h01 << i));
			wr(8'h59, ~(8'h01 << i));
			sup_in = 8'h01 << i;
			bus_in = 8'h01 << i;
			settle();
			wr(8'h57, 8'h01 << i);
			settle();
			wr(8'h59, 8'h01 << i);
			settle();
		end
		for (int i = 0; i < 30; i++)
		begin
			wr(8'h57, rnd());
			wr(8'h59, rnd());
			sup_in = rnd();
			bus_in = rnd();
			settle();
		end
		wr(8'h57, 8'h00);
		wr(8'h59, 8'h00);
		wr(8'h58, 8'h80);
		err_in = 1;
		@(posedge clk_in);
		#1 err_in = 0;
		sflag = 1;
		settle();
		rd(8'h53);
		wr(8'h58, 8'h00);
		settle();
		wr(8'h53, 8'h80);
		rd(8'h53);
		wr(8'h58, 8'hFF);
		settle();
		// error event held across a clearing write: set wins
		err_in = 1;
		wr(8'h53, 8'h80);
		err_in = 0;
		sflag = 1;
		rd(8'h53);
		settle();
		rst_in = 1;
		repeat (2) @(posedge clk_in);
		#1 rst_in = 0;
		mv = 24'h3F807F;
		sflag = 0;
		chk("masks", mv, masks_out);
		settle();
		summarize();
	end
	initial
	begin
		#3000000;
		error_cnt++;
		summarize();
	end
endmodule
